// file: shared/bram_pkg.sv
/*
  Constants shared by the dual port block ram: register map, field
  positions, reset values, width selector codes and storage geometry.
  Assumes a single system clock domain for everything that uses it.
*/
package bram_pkg;

  // storage row: four lanes of nine bits, lane 0 in the low bits
  localparam int ROW_BITS  = 36;
  localparam int LANE_BITS = 9;
  localparam int SYNC_FILL = 3;

  // width selector codes, six defined, two reserved
  localparam logic [2:0] WSEL_1  = 3'h0;
  localparam logic [2:0] WSEL_2  = 3'h1;
  localparam logic [2:0] WSEL_4  = 3'h2;
  localparam logic [2:0] WSEL_9  = 3'h3;
  localparam logic [2:0] WSEL_18 = 3'h4;
  localparam logic [2:0] WSEL_36 = 3'h5;

  // wishbone register map (byte addresses)
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // control fields
  localparam int CTRL_WR_FALL = 0;
  localparam int CTRL_RD_FALL = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // status fields
  localparam int STAT_WR_RSVD = 0;
  localparam int STAT_RD_RSVD = 1;
  localparam int STAT_PIPE    = 2;
  localparam int STAT_HOLD    = 3;

endpackage

// file: verilog/lane_ram_store.sv
/*
  Row storage for the block ram: one write with a bit mask and one
  registered read per clock. Assumes the caller has already placed the
  dataword on the right bits of a row.
*/
`timescale 1ns/1ps
`default_nettype none

module lane_ram_store
  import bram_pkg::*;
#(
  parameter int ROW_W = 11
)(
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                wr_go,
  input  wire logic [ROW_W-1:0]    wr_row,
  input  wire logic [ROW_BITS-1:0] wr_bits,
  input  wire logic [ROW_BITS-1:0] wr_mask,
  input  wire logic                rd_go,
  input  wire logic [ROW_W-1:0]    rd_row,
  output logic      [ROW_BITS-1:0] rd_bits
);

  logic [ROW_BITS-1:0] mem [0:(1<<ROW_W)-1];

  // only masked bits change, the rest of the row keeps its word
  always_ff @(posedge clock)
  begin
    if (wr_go)
      mem[wr_row] <= (mem[wr_row] & ~wr_mask) | (wr_bits & wr_mask);
  end

  // read samples before this edge's write lands: old data on collision
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rd_bits <= '0;
    else if (rd_go)
      rd_bits <= mem[rd_row];
  end

endmodule // lane_ram_store

`default_nettype wire

// file: verilog/dual_port_block_ram.sv
/*
  Dual port block ram: one write port and one read port, each timed by
  its own fabric clock pin whose active edge is chosen in a register.
  Both pins are oversampled by the system clock, so each pin clock must
  stay well below a third of the system clock rate. Configuration and
  status sit on a classic wishbone slave.
*/
// Functional notes
// - bytes of a dataword are placed little-endian, low address low lane
// - write port runs on its own write clock, either edge selectable
// - read port runs on its own read clock, either edge selectable
// - write address top bit index spans 10 to 15 by configuration
// - read address top bit index spans 10 to 15 by configuration
// - both data buses carry words of 1, 2, 4, 9, 18 or 36 bits
// - read enable at active read edge returns data at read address
// - write enable at active write edge stores write data, else nothing
// - pipe select picks pipelined or plain reads; writes take one edge
// - plain read: address registered, data follows within the next cycle
// - pipelined read: data registered, shown after the following edge
`timescale 1ns/1ps
`default_nettype none

module dual_port_block_ram
  import bram_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                wr_clk_pin,
  input  wire logic                wr_en,
  input  wire logic [ADDR_W-1:0]   wr_addr,
  input  wire logic [ROW_BITS-1:0] wr_data,
  input  wire logic [2:0]          wr_width_sel,
  input  wire logic                rd_clk_pin,
  input  wire logic                rd_en,
  input  wire logic [ADDR_W-1:0]   rd_addr,
  input  wire logic [2:0]          rd_width_sel,
  input  wire logic                pipe_sel,
  output logic      [ROW_BITS-1:0] rd_data,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o
);

  localparam int ROW_W = ADDR_W - 5;
  localparam int WPIN_W = 1 + ADDR_W + ROW_BITS + 3;
  localparam int RPIN_W = 1 + ADDR_W + 3 + 1;

  // width code to the low-bit mask of one dataword
  function automatic logic [ROW_BITS-1:0] word_ones(input logic [2:0] c);
    unique case (c)
      WSEL_1:  word_ones = 36'h0_0000_0001;
      WSEL_2:  word_ones = 36'h0_0000_0003;
      WSEL_4:  word_ones = 36'h0_0000_000f;
      WSEL_9:  word_ones = 36'h0_0000_01ff;
      WSEL_18: word_ones = 36'h0_0003_ffff;
      WSEL_36: word_ones = 36'hf_ffff_ffff;
      default: word_ones = 36'h0_0000_0000;
    endcase
  endfunction

  function automatic logic code_ok(input logic [2:0] c);
    code_ok = (c <= WSEL_36);
  endfunction

  // bit position of the word inside its row, lower address in lower lane
  function automatic logic [5:0] bit_ofs(input logic [2:0] c,
                                         input logic [ADDR_W-1:0] a);
    logic [5:0] lane;
    lane = 6'h0;
    bit_ofs = 6'h0;
    unique case (c)
      WSEL_1:
      begin
        lane = {4'h0, a[4:3]};
        bit_ofs = 6'(lane * 6'd9) + {3'h0, a[2:0]};
      end
      WSEL_2:
      begin
        lane = {4'h0, a[3:2]};
        bit_ofs = 6'(lane * 6'd9) + {3'h0, a[1:0], 1'b0};
      end
      WSEL_4:
      begin
        lane = {4'h0, a[2:1]};
        bit_ofs = 6'(lane * 6'd9) + {3'h0, a[0], 2'h0};
      end
      WSEL_9:  bit_ofs = 6'({4'h0, a[1:0]} * 6'd9);
      WSEL_18: bit_ofs = a[0] ? 6'd18 : 6'd0;
      default: bit_ofs = 6'h0;
    endcase
  endfunction

  // row index: narrower words pack more addresses into one row
  function automatic logic [ROW_W-1:0] row_of(input logic [2:0] c,
                                              input logic [ADDR_W-1:0] a);
    unique case (c)
      WSEL_1:  row_of = ROW_W'(a >> 5);
      WSEL_2:  row_of = ROW_W'(a >> 4);
      WSEL_4:  row_of = ROW_W'(a >> 3);
      WSEL_9:  row_of = ROW_W'(a >> 2);
      WSEL_18: row_of = ROW_W'(a >> 1);
      default: row_of = ROW_W'(a);
    endcase
  endfunction

  // pin synchronisers; data lags one more stage than the clock pin so a
  // sampled word always predates the edge that strobes it
  logic [1:0]        clk_s1;
  logic [1:0]        clk_s2;
  logic [1:0]        clk_s3;
  logic [WPIN_W-1:0] wpin_s1;
  logic [WPIN_W-1:0] wpin_s2;
  logic [WPIN_W-1:0] wpin_s3;
  logic [RPIN_W-1:0] rpin_s1;
  logic [RPIN_W-1:0] rpin_s2;
  logic [RPIN_W-1:0] rpin_s3;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk_s1  <= '0;
      clk_s2  <= '0;
      clk_s3  <= '0;
      wpin_s1 <= '0;
      wpin_s2 <= '0;
      wpin_s3 <= '0;
      rpin_s1 <= '0;
      rpin_s2 <= '0;
      rpin_s3 <= '0;
    end
    else
    begin
      clk_s1  <= {wr_clk_pin, rd_clk_pin};
      clk_s2  <= clk_s1;
      clk_s3  <= clk_s2;
      wpin_s1 <= {wr_en, wr_addr, wr_data, wr_width_sel};
      wpin_s2 <= wpin_s1;
      wpin_s3 <= wpin_s2;
      rpin_s1 <= {rd_en, rd_addr, rd_width_sel, pipe_sel};
      rpin_s2 <= rpin_s1;
      rpin_s3 <= rpin_s2;
    end
  end

  logic                w_en;
  logic [ADDR_W-1:0]   w_addr;
  logic [ROW_BITS-1:0] w_data;
  logic [2:0]          w_code;
  logic                r_en;
  logic [ADDR_W-1:0]   r_addr;
  logic [2:0]          r_code;
  logic                r_pipe;

  assign {w_en, w_addr, w_data, w_code} = wpin_s3;
  assign {r_en, r_addr, r_code, r_pipe} = rpin_s3;

  // edges seen before the synchronisers fill would be reset artefacts
  logic [1:0] fill_cnt;
  logic       armed;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      fill_cnt <= 2'h0;
    else if (!armed)
      fill_cnt <= fill_cnt + 2'h1;
  end

  assign armed = (fill_cnt == 2'(SYNC_FILL));

  logic [1:0] ctrl;
  logic       wr_event;
  logic       rd_event;

  assign wr_event = armed && (ctrl[CTRL_WR_FALL] ?
                    (clk_s3[1] && !clk_s2[1]) : (!clk_s3[1] && clk_s2[1]));
  assign rd_event = armed && (ctrl[CTRL_RD_FALL] ?
                    (clk_s3[0] && !clk_s2[0]) : (!clk_s3[0] && clk_s2[0]));

  // write port: place the word in its row with a matching bit mask
  logic                wr_go;
  logic [ROW_W-1:0]    wr_row;
  logic [ROW_BITS-1:0] wr_bits;
  logic [ROW_BITS-1:0] wr_mask;
  logic [5:0]          w_ofs;

  assign w_ofs = bit_ofs(w_code, w_addr);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_go   <= 1'b0;
      wr_row  <= '0;
      wr_bits <= '0;
      wr_mask <= '0;
    end
    else
    begin
      wr_go <= wr_event && w_en && code_ok(w_code);
      if (wr_event)
      begin
        wr_row  <= row_of(w_code, w_addr);
        wr_bits <= (w_data & word_ones(w_code)) << w_ofs;
        wr_mask <= word_ones(w_code) << w_ofs;
      end
    end
  end

  // read port: capture address on the active edge
  logic             rd_go;
  logic [ROW_W-1:0] rd_row;
  logic [5:0]       rd_ofs;
  logic [2:0]       rd_code;
  logic             rd_pipe;
  logic             rd_pend;
  logic [ROW_BITS-1:0] rd_bits;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_go   <= 1'b0;
      rd_row  <= '0;
      rd_ofs  <= 6'h0;
      rd_code <= WSEL_1;
      rd_pipe <= 1'b0;
    end
    else
    begin
      rd_go <= rd_event && r_en;
      if (rd_event && r_en)
      begin
        rd_row  <= row_of(r_code, r_addr);
        rd_ofs  <= bit_ofs(r_code, r_addr);
        rd_code <= r_code;
        rd_pipe <= r_pipe;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rd_pend <= 1'b0;
    else
      rd_pend <= rd_go;
  end

  // write and read queued for the same edge see the old row
  lane_ram_store #(
    .ROW_W   (ROW_W)
  ) u_store (
    .clock   (clock),
    .reset_n (reset_n),
    .wr_go   (wr_go),
    .wr_row  (wr_row),
    .wr_bits (wr_bits),
    .wr_mask (wr_mask),
    .rd_go   (rd_go),
    .rd_row  (rd_row),
    .rd_bits (rd_bits)
  );

  // reserved codes read back as zero
  logic [ROW_BITS-1:0] rd_word;
  assign rd_word = (rd_bits >> rd_ofs) & word_ones(rd_code);

  // pipelined word waits in a hold stage until the next active edge
  logic [ROW_BITS-1:0] hold_word;
  logic                hold_ok;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold_word <= '0;
      hold_ok   <= 1'b0;
    end
    else if (rd_pend && rd_pipe)
    begin
      hold_word <= rd_word;
      hold_ok   <= 1'b1;
    end
    else if (rd_event && r_pipe)
      hold_ok <= 1'b0;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rd_data <= '0;
    else if (rd_pend && !rd_pipe)
      rd_data <= rd_word;
    else if (rd_event && r_pipe && hold_ok)
      rd_data <= hold_word;
  end

  // wishbone slave: one registered ack per request, the cycle after the strobe
  logic wb_req;
  logic wr_rsvd;
  logic rd_rsvd;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // writes land on the edge at which the master sees ack
  logic wb_wr;
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      ctrl <= CTRL_RESET;
    else if (wb_wr && wb_sel_i[0] && wb_adr_i == CTRL_OFS)
      ctrl <= wb_dat_i[1:0];
  end

  // sticky flags, write one to clear; a new hit outranks the clear
  logic clr_st;
  assign clr_st = wb_wr && wb_sel_i[0] && wb_adr_i == STATUS_OFS;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_rsvd <= 1'b0;
      rd_rsvd <= 1'b0;
    end
    else
    begin
      if (wr_event && w_en && !code_ok(w_code))
        wr_rsvd <= 1'b1;
      else if (clr_st && wb_dat_i[STAT_WR_RSVD])
        wr_rsvd <= 1'b0;
      if (rd_event && r_en && !code_ok(r_code))
        rd_rsvd <= 1'b1;
      else if (clr_st && wb_dat_i[STAT_RD_RSVD])
        rd_rsvd <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_req && !wb_we_i)
    begin
      wb_dat_o <= 32'h0000_0000;
      if (wb_adr_i == CTRL_OFS)
        wb_dat_o[1:0] <= ctrl;
      else if (wb_adr_i == STATUS_OFS)
      begin
        wb_dat_o[STAT_WR_RSVD] <= wr_rsvd;
        wb_dat_o[STAT_RD_RSVD] <= rd_rsvd;
        wb_dat_o[STAT_PIPE]    <= r_pipe;
        wb_dat_o[STAT_HOLD]    <= hold_ok;
      end
    end
  end

endmodule // dual_port_block_ram

`default_nettype wire

// file: test/dual_port_block_ram_assertions.sv
/* Port checker for the block ram top.
   Assumes a bus master that holds each request until ack. */
`timescale 1ns/1ps
`default_nettype none

module dual_port_block_ram_assertions
  import bram_pkg::*;
(
  input wire logic                clock,
  input wire logic                reset_n,
  input wire logic                rd_clk_pin,
  input wire logic [2:0]          rd_width_sel,
  input wire logic                pipe_sel,
  input wire logic [ROW_BITS-1:0] rd_data,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o
);
  logic [3:0] quiet;

  // idle time of the read pin; results must land before it passes 11
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      quiet <= 4'h0;
    else if ($changed(rd_clk_pin))
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");

  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");

  property p_unmapped;
    wb_ack_o && !wb_we_i && wb_adr_i != CTRL_OFS &&
      wb_adr_i != STATUS_OFS |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");

  property p_ctrl_bits;
    wb_ack_o && !wb_we_i && wb_adr_i == CTRL_OFS |-> wb_dat_o[31:2] == 30'h0;
  endproperty
  a_ctrl_bits: assert property (p_ctrl_bits) else $error("ctrl bits");

  property p_pipe_seen;
    $stable(pipe_sel) [*6] ##0 (wb_ack_o && !wb_we_i &&
      wb_adr_i == STATUS_OFS) |-> wb_dat_o[STAT_PIPE] == pipe_sel;
  endproperty
  a_pipe_seen: assert property (p_pipe_seen) else $error("pipe bit");

  property p_quiet;
    quiet > 4'hb |-> $stable(rd_data);
  endproperty
  a_quiet: assert property (p_quiet) else $error("late read data");

  // only plain reads with a settled code tell which width a word has
  property p_narrow;
    (!pipe_sel && $stable({rd_width_sel, pipe_sel})) [*8] ##0
      ($changed(rd_data) && rd_width_sel == WSEL_1)
      |-> rd_data[35:1] == 35'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper bits set");

  property p_reserved;
    (!pipe_sel && $stable({rd_width_sel, pipe_sel})) [*8] ##0
      ($changed(rd_data) && rd_width_sel[2:1] == 2'h3)
      |-> rd_data == 36'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved data");

  c_pipe: cover property (wb_ack_o && wb_dat_o[STAT_PIPE]);
  c_narrow: cover property ($changed(rd_data) && rd_width_sel == WSEL_1);
  c_unmapped: cover property (wb_ack_o && wb_adr_i == 8'h08);
endmodule // dual_port_block_ram_assertions

bind dual_port_block_ram dual_port_block_ram_assertions i_chk (
  .clock, .reset_n, .rd_clk_pin, .rd_width_sel, .pipe_sel, .rd_data,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o
);

`default_nettype wire

// file: test/fabric_user_model.sv
/* Fabric user logic driving both ram ports through pin clocks.
   Assumes calls start after the ram's synchroniser fill. */
`timescale 1ns/1ps
`default_nettype none

module fabric_user_model
  import bram_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  input  wire logic                clock,
  input  wire logic                fall_edge,
  output logic                     wr_clk_pin,
  output logic                     wr_en,
  output logic      [ADDR_W-1:0]   wr_addr,
  output logic      [ROW_BITS-1:0] wr_data,
  output logic      [2:0]          wr_width_sel,
  output logic                     rd_clk_pin,
  output logic                     rd_en,
  output logic      [ADDR_W-1:0]   rd_addr,
  output logic      [2:0]          rd_width_sel,
  output logic                     pipe_sel
);
  initial
  begin
    {wr_clk_pin, wr_en, wr_addr, wr_data, wr_width_sel} = '0;
    {rd_clk_pin, rd_en, rd_addr, rd_width_sel, pipe_sel} = '0;
  end

  // address and data valid only around the chosen edge, inverted around the other,
  // so a port acting on the wrong edge picks up garbage
  task automatic xfer(input logic rd, input logic [2:0] w,
                      input logic p, input logic [ADDR_W-1:0] a,
                      input logic [ROW_BITS-1:0] d, input logic en);
    int i;
    for (i = 0; i < 4; i++)
    begin
      @(posedge clock);
      if (i[0] && rd)
        rd_clk_pin <= ~i[1];
      else if (i[0])
        wr_clk_pin <= ~i[1];
      else if (rd)
      begin
        rd_en <= en;
        rd_width_sel <= w;
        pipe_sel <= p;
        rd_addr <= (fall_edge ^ i[1]) ? ~a : a;
      end
      else
      begin
        wr_en <= en;
        wr_width_sel <= w;
        wr_addr <= (fall_edge ^ i[1]) ? ~a : a;
        wr_data <= (fall_edge ^ i[1]) ? ~d : d;
      end
      repeat (i == 3 ? 10 : 3) @(posedge clock);
    end
  endtask

  // both ports hit one row on the same pin edge
  task automatic clash(input logic [ADDR_W-1:0] a,
                       input logic [ROW_BITS-1:0] d);
    int i;
    for (i = 0; i < 4; i++)
    begin
      @(posedge clock);
      if (i[0])
      begin
        wr_clk_pin <= ~i[1];
        rd_clk_pin <= ~i[1];
      end
      else
      begin
        {wr_en, rd_en, pipe_sel} <= 3'h6;
        wr_width_sel <= WSEL_36;
        rd_width_sel <= WSEL_36;
        wr_addr <= (fall_edge ^ i[1]) ? ~a : a;
        rd_addr <= (fall_edge ^ i[1]) ? ~a : a;
        wr_data <= (fall_edge ^ i[1]) ? ~d : d;
      end
      repeat (i == 3 ? 10 : 3) @(posedge clock);
    end
  endtask
endmodule // fabric_user_model

`default_nettype wire

// file: test/dual_port_block_ram_tb_top.sv
/* Self-checking bench for the block ram: bus tasks and port accesses.
   Assumes bram_pkg and the fabric user model. */
`timescale 1ns/1ps
`default_nettype none

module dual_port_block_ram_tb_top
  import bram_pkg::*;
  ;
  localparam logic [35:0] PAT = 36'h93c5a6b21;
  logic        clock = 1'h0;
  logic        reset_n = 1'h0;
  logic        fall_edge = 1'h0;
  logic        wr_clk_pin, wr_en, rd_clk_pin, rd_en, pipe_sel, wb_ack_o;
  logic [2:0]  wr_width_sel, rd_width_sel;
  logic [15:0] wr_addr, rd_addr, a;
  logic [35:0] wr_data, rd_data, m, nar, exp_row [6];
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [3:0]  wb_sel_i = 4'hf;
  int          miscompares = 0, check_count = 0, k, i, w, p;

  always #4 clock = ~clock;

  dual_port_block_ram i_dut (
    .clock, .reset_n, .wr_clk_pin, .wr_en, .wr_addr, .wr_data,
    .wr_width_sel, .rd_clk_pin, .rd_en, .rd_addr, .rd_width_sel,
    .pipe_sel, .rd_data, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o
  );

  fabric_user_model i_fab (
    .clock, .fall_edge, .wr_clk_pin, .wr_en, .wr_addr, .wr_data,
    .wr_width_sel, .rd_clk_pin, .rd_en, .rd_addr, .rd_width_sel,
    .pipe_sel
  );

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] ad,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'h1 && n < 16);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (wb_ack_o !== 1'h1)
    begin
      miscompares++;
      end_sim;
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clock);
    reset_n <= 1'h1;
    repeat (4) @(posedge clock);
    wb(1'h0, CTRL_OFS, 32'h0);
    check({4'h0, q}, 36'h0);
    wb(1'h1, 8'h08, 32'h3);
    wb(1'h0, 8'h08, 32'h0);
    check({4'h0, q}, 36'h0);
    $display("test registers done");
    for (k = 0; k < 6; k++)
    begin
      w = k < 3 ? 1 << k : 9 << (k - 3);
      i = (1 << (5 - k)) - 1;
      p = w < 9 ? i / (8 / w) * 9 + i % (8 / w) * w : i * w;
      m = ((36'h1 << w) - 36'h1) << p;
      nar = ~(PAT >> p) & ((36'h1 << w) - 36'h1);
      exp_row[k] = (PAT & ~m) | (nar << p);
      a = 16'(k + 1);
      i_fab.xfer(1'h0, WSEL_36, 1'h0, a, PAT, 1'h1);
      i_fab.xfer(1'h0, 3'(k), 1'h0, (a << (5 - k)) | 16'(i), nar, 1'h1);
      i_fab.xfer(1'h1, WSEL_36, 1'h0, a, 36'h0, 1'h1);
      check(rd_data, exp_row[k]);
      i_fab.xfer(1'h1, 3'(k), 1'h0, (a << (5 - k)) | 16'(i), 36'h0, 1'h1);
      check(rd_data, nar);
    end
    $display("test widths done");
    i_fab.xfer(1'h0, WSEL_36, 1'h0, 16'h1, 36'h0, 1'h0);
    i_fab.xfer(1'h0, 3'h6, 1'h0, 16'h1, 36'h0, 1'h1);
    i_fab.xfer(1'h1, WSEL_36, 1'h0, 16'h1, 36'h0, 1'h1);
    check(rd_data, exp_row[0]);
    i_fab.xfer(1'h1, WSEL_36, 1'h0, 16'h2, 36'h0, 1'h0);
    check(rd_data, exp_row[0]);
    i_fab.xfer(1'h1, 3'h7, 1'h0, 16'h2, 36'h0, 1'h1);
    check(rd_data, 36'h0);
    wb(1'h0, STATUS_OFS, 32'h0);
    check({4'h0, q}, 36'h3);
    wb(1'h1, STATUS_OFS, 32'h3);
    wb(1'h0, STATUS_OFS, 32'h0);
    check({4'h0, q}, 36'h0);
    $display("test refusals done");
    i_fab.xfer(1'h1, WSEL_36, 1'h1, 16'h1, 36'h0, 1'h1);
    check(rd_data, 36'h0);
    i_fab.xfer(1'h1, WSEL_36, 1'h1, 16'h2, 36'h0, 1'h1);
    check(rd_data, exp_row[0]);
    wb(1'h0, STATUS_OFS, 32'h0);
    check({4'h0, q}, 36'hc);
    i_fab.xfer(1'h1, WSEL_36, 1'h1, 16'h3, 36'h0, 1'h1);
    check(rd_data, exp_row[1]);
    $display("test pipeline done");
    fall_edge <= 1'h1;
    wb(1'h1, CTRL_OFS, 32'h3);
    wb(1'h0, CTRL_OFS, 32'h0);
    check({4'h0, q}, 36'h3);
    i_fab.xfer(1'h0, WSEL_36, 1'h0, 16'h7, PAT, 1'h1);
    i_fab.xfer(1'h1, WSEL_36, 1'h0, 16'h7, 36'h0, 1'h1);
    check(rd_data, PAT);
    i_fab.xfer(1'h1, WSEL_36, 1'h0, 16'h2, 36'h0, 1'h1);
    check(rd_data, exp_row[1]);
    i_fab.clash(16'h7, ~PAT);
    check(rd_data, PAT);
    i_fab.xfer(1'h1, WSEL_36, 1'h0, 16'h7, 36'h0, 1'h1);
    check(rd_data, ~PAT);
    $display("test edges done");
    end_sim;
  end
endmodule // dual_port_block_ram_tb_top

`default_nettype wire
